// [src/host_port_mode_select.sv]
`timescale 1ns/1ns
`default_nettype none
module host_port_mode_select #(
  parameter logic [7:0] ROM_ADDR = host_port_pkg::BOOT_ADDR
) (
  // Clock and reset
  input  wire  logic                       ref_clk,
  input  wire  logic                       rstn,

  // Strap pins
  input  wire  logic [2:0]                 mode_pins,

  // Register access
  input  wire  host_port_pkg::reg_req_t    reg_req,
  output logic [7:0]                       reg_rdata,

  // Boot EPROM
  output logic                             rom_rd,
  output logic [7:0]                       rom_addr,
  input  wire  logic                       rom_valid,
  input  wire  logic [7:0]                 rom_data,

  // Mode to the interface logic
  output logic [2:0]                       host_mode,
  output var   host_port_pkg::mode_onehot_t host_sel,
  output logic                             boot_done
);
  import host_port_pkg::*;

  // Complete state of the block, registered as one word
  select_state_t s_q;
  select_state_t s_d;

  // Mode field held in the low bits of a byte
  function automatic logic [2:0] field_of(input logic [7:0] b);
    logic [2:0] f;
    f = b[FIELD_LSB +: FIELD_W];
    return f;
  endfunction

  // Address match for the mode register
  function automatic logic is_select(input logic [7:0] a);
    logic hit;
    hit = (a == SELECT_OFFSET);
    return hit;
  endfunction

  // A write strobe aimed at the mode register
  function automatic logic write_hit(input reg_req_t q);
    logic h;
    h = q.wr && is_select(q.addr);
    return h;
  endfunction

  // Read value: mode in the low bits, unused bits forced low
  function automatic logic [7:0] readback(input logic [2:0] m);
    logic [7:0] r;
    r                       = RDATA_IDLE;
    r[FIELD_LSB +: FIELD_W] = m;
    return r;
  endfunction

  // Strap decision taken on the first edge out of reset
  function automatic logic needs_boot(input logic [2:0] m);
    logic b;
    b = (m == MODE_EPROM);
    return b;
  endfunction

  // Protocol one-hot; unused codes select nothing
  function automatic mode_onehot_t decode(input logic [2:0] m);
    mode_onehot_t o;
    o = '0;
    unique case (m)
      MODE_EPROM:
      begin
        o.eprom = 1'b1;
      end
      MODE_MUX:
      begin
        o.mux = 1'b1;
      end
      MODE_INTEL:
      begin
        o.intel = 1'b1;
      end
      MODE_MOTOROLA:
      begin
        o.motorola = 1'b1;
      end
      MODE_SERIAL:
      begin
        o.serial = 1'b1;
      end
      default:
      begin
        // Codes 000, 110 and 111 leave every protocol off
        o = '0;
      end
    endcase
    return o;
  endfunction

  always_comb
  begin
    // Hold everything except rom_rd, which drops low, unless a branch below says otherwise
    s_d          = s_q;
    s_d.rom_rd   = 1'b0;
    s_d.rom_addr = ROM_ADDR;

    unique case (s_q.state)
      ST_STRAP:
      begin
        // First edge after reset release catches the straps
        s_d.mode = mode_pins;
        if (needs_boot(mode_pins))
        begin
          // Host writes are dropped, not held, until the boot byte arrives; reads are still answered
          s_d.state     = ST_BOOT_REQ;
          s_d.boot_done = 1'b0;
        end
        else
        begin
          s_d.state     = ST_RUN;
          s_d.boot_done = 1'b1;
        end
      end

      ST_BOOT_REQ:
      begin
        // One-cycle read request for the boot byte
        s_d.rom_rd = 1'b1;
        s_d.state  = ST_BOOT_WAIT;
      end

      ST_BOOT_WAIT:
      begin
        // Writes are refused until the boot byte has arrived
        if (rom_valid)
        begin
          s_d.mode      = field_of(rom_data);
          s_d.state     = ST_RUN;
          s_d.boot_done = 1'b1;
        end
        else
        begin
          s_d.state = ST_BOOT_WAIT;
        end
      end

      ST_RUN:
      begin
        // Pins are no longer looked at here
        if (write_hit(reg_req))
        begin
          // Only the field bits are kept
          s_d.mode = field_of(reg_req.wdata);
        end
        else
        begin
          s_d.mode = s_q.mode;
        end
        s_d.state = ST_RUN;
      end
    endcase

    // Protocol select follows the mode in the same edge
    s_d.sel = decode(s_d.mode);

    // Read data answers the address one cycle later
    if (is_select(reg_req.addr))
    begin
      s_d.rdata = readback(s_q.mode);
    end
    else
    begin
      s_d.rdata = RDATA_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      // Known quiet state; straps are caught on release
      s_q           <= '0;
      s_q.state     <= ST_STRAP;
      s_q.mode      <= MODE_RESET;
      s_q.sel       <= '0;
      s_q.rom_rd    <= 1'b0;
      s_q.rom_addr  <= ROM_ADDR;
      s_q.rdata     <= RDATA_IDLE;
      s_q.boot_done <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Every output is a register of the state word
  assign reg_rdata = s_q.rdata;
  assign rom_rd    = s_q.rom_rd;
  assign rom_addr  = s_q.rom_addr;
  assign host_mode = s_q.mode;
  assign host_sel  = s_q.sel;
  assign boot_done = s_q.boot_done;

endmodule
`default_nettype wire

// [src/host_port_pkg.sv]
package host_port_pkg;

  localparam logic [2:0] MODE_NONE     = 3'h0;
  localparam logic [2:0] MODE_EPROM    = 3'h1;
  localparam logic [2:0] MODE_MUX      = 3'h2;
  localparam logic [2:0] MODE_INTEL    = 3'h3;
  localparam logic [2:0] MODE_MOTOROLA = 3'h4;
  localparam logic [2:0] MODE_SERIAL   = 3'h5;

  localparam int         FIELD_LSB     = 0;
  localparam int         FIELD_W       = 3;
  localparam logic [7:0] BOOT_ADDR     = 8'h7F;
  localparam logic [7:0] SELECT_OFFSET = 8'h00;
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [7:0] RDATA_IDLE    = 8'h00;

  typedef enum {
    ST_STRAP,
    ST_BOOT_REQ,
    ST_BOOT_WAIT,
    ST_RUN
  } boot_state_t;

  // One-hot protocol selection presented to the interface logic
  typedef struct packed {
    logic eprom;
    logic mux;
    logic intel;
    logic motorola;
    logic serial;
  } mode_onehot_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    boot_state_t  state;
    logic [2:0]   mode;
    mode_onehot_t sel;
    logic         rom_rd;
    logic [7:0]   rom_addr;
    logic [7:0]   rdata;
    logic         boot_done;
  } select_state_t;

endpackage

// [verif/boot_rom.sv]
`timescale 1ns/1ns
`default_nettype none
module boot_rom (
  input wire logic ref_clk, rom_rd,
  input wire logic [7:0] rom_addr,
  output logic rom_valid = 1'h0,
  output logic [7:0] rom_data = 8'h00);
  int n = 0;
  // Answers three edges after the edge that samples rom_rd; data toggles outside a reply
  always @(posedge ref_clk)
  begin
    n <= rom_rd ? 3 : n - (n > 0);
    rom_valid <= n == 1;
    rom_data <= n == 1 && rom_addr == 8'h7F ? 8'hFB : ~rom_data;
  end
endmodule
`default_nettype wire

// [verif/host_port_mode_select_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module host_port_mode_select_bench;
  import host_port_pkg::*;
  logic ref_clk = 0, rstn = 0, rom_rd, rom_valid, boot_done;
  logic [2:0] mode_pins = 3'h1, host_mode;
  logic [7:0] reg_rdata, rom_addr, rom_data;
  reg_req_t reg_req = '0;
  mode_onehot_t host_sel;
  int err_count = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  host_port_mode_select u_dut (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .mode_pins (mode_pins),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .rom_rd    (rom_rd),
    .rom_addr  (rom_addr),
    .rom_valid (rom_valid),
    .rom_data  (rom_data),
    .host_mode (host_mode),
    .host_sel  (host_sel),
    .boot_done (boot_done)
  );
  boot_rom u_rom (
    .ref_clk   (ref_clk),
    .rom_rd    (rom_rd),
    .rom_addr  (rom_addr),
    .rom_valid (rom_valid),
    .rom_data  (rom_data)
  );
  task chk(input logic [7:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  task stop_test;
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Write one byte; the strobe stands for one edge
  task wr(input logic [7:0] a, d);
    reg_req = {1'b1, a, d};
    @(negedge ref_clk) reg_req.wr = 1'b0;
  endtask
  // Returns at the falling edge after the first edge out of reset
  task boot(input logic [2:0] p);
    rstn = 0;
    mode_pins = p;
    repeat (6) @(negedge ref_clk);
    rstn = 1;
    @(negedge ref_clk);
  endtask
  initial
  begin
    #2000 err_count++;
    stop_test;
  end
  initial
  begin
    boot(MODE_EPROM);
    chk(boot_done, 8'h00);
    wr(SELECT_OFFSET, 8'h02);
    mode_pins = 3'h0;
    repeat (10) @(negedge ref_clk);
    chk(host_mode, 8'h03);
    chk(boot_done, 8'h01);
    chk(rom_addr, 8'h7F);
    for (int i = 0; i < 8; i++)
    begin
      wr(SELECT_OFFSET, 8'hF8 | 8'(i));
      @(negedge ref_clk) chk(host_sel, i % 6 ? 6'h20 >> i : 0);
      chk(reg_rdata, 8'(i));
    end
    wr(8'h01, 8'h05);
    @(negedge ref_clk) chk(host_mode, 8'h07);
    chk(reg_rdata, 8'h00);
    boot(MODE_MOTOROLA);
    chk(host_sel, 8'h02);
    chk(host_mode, 8'h04);
    mode_pins = 3'h5;
    repeat (2) @(negedge ref_clk);
    chk(host_mode, 8'h04);
    stop_test;
  end
endmodule
`default_nettype wire

// [verif/sel_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module sel_asserts (
  input wire logic                        ref_clk,
  input wire logic                        rstn,
  input wire logic                        rom_rd,
  input wire logic                        rom_valid,
  input wire logic                        boot_done,
  input wire logic [2:0]                  mode_pins,
  input wire logic [2:0]                  host_mode,
  input wire logic [7:0]                  reg_rdata,
  input wire logic [7:0]                  rom_data,
  input wire host_port_pkg::reg_req_t     reg_req,
  input wire host_port_pkg::mode_onehot_t host_sel
);
  import host_port_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_sel_decode: assert property ({1'b0, host_sel} ==
    (host_mode == 0 ? 6'h00 : 6'h20 >> host_mode)) else $error("sel");
  chk_strap_load: assert property ($rose(rstn) |-> ##2
    host_mode == $past(mode_pins, 2)) else $error("strap");
  chk_pins_ignored: assert property (boot_done && !reg_req.wr |=>
    $stable(host_mode)) else $error("pins");
  chk_boot_load: assert property (rom_valid && !boot_done |=>
    boot_done && host_mode == $past(rom_data[2:0])) else $error("boot");
  chk_upper_zero: assert property (reg_rdata[7:3] == 5'h00)
    else $error("upper");
  chk_rom_pulse: assert property (rom_rd |=> !rom_rd)
    else $error("rom request longer than one cycle");
  chk_early_write: assert property (reg_req.wr && !boot_done &&
    !rom_valid && host_mode == MODE_EPROM |=> host_mode == MODE_EPROM)
    else $error("write taken before boot finished");
  cover property (rom_rd);
  cover property (reg_req.wr && !boot_done);
  cover property ($rose(boot_done));
  cover property (reg_req.wr);
endmodule
bind host_port_mode_select sel_asserts u_chk (
  .ref_clk   (ref_clk),
  .rstn      (rstn),
  .rom_rd    (rom_rd),
  .rom_valid (rom_valid),
  .boot_done (boot_done),
  .mode_pins (mode_pins),
  .host_mode (host_mode),
  .reg_rdata (reg_rdata),
  .rom_data  (rom_data),
  .reg_req   (reg_req),
  .host_sel  (host_sel)
);
`default_nettype wire
